// ===== cgb_config_bank.sv
`default_nettype none
// Summary of operation
// [R1] disabled reference drives per two-bit field
// [R2] disable-state field, low two bits, location 11
// [R3] location 5 revision and vendor, read-only
// [R4] location 6 type and identifier, read-only
// [R5] location 7 read length, resets eight
// [R6] location 10 bit 7 divider programming enable
// [R7] location 10 bit 6 keep config in powerdown
// [R8] two-bit impedance per output, locations 12,13
// [R9] location 14 enable termination, resets pull-down
// [R10] location 15 enable termination, upper inputs
// [R11] location 16 power-good termination, resets pull-up
// [R12] location 18 enable polarity per input
// [R13] location 19 bit 0 power-down polarity
// [R14] locations 4,8,9,17 unused, read zero
// [R15] block write stores consecutive locations, acked
// [R16] block read returns count then data
// [R17] cleared enable bit forces disabled state
// [R18] read-only and reserved writes acked, ignored
module cgb_config_bank #(
  parameter logic [3:0] REVISION = 4'h3, // arbitrary value
  parameter logic [3:0] VENDOR = 4'h5, // arbitrary value
  parameter logic [1:0] DEV_TYPE = 2'h2, // arbitrary value
  parameter logic [5:0] DEV_IDENT = 6'h15, // arbitrary value
  parameter int NUM_OUT = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic bus_address_select_pin,
  // power and enables
  input wire logic power_good_powerdown_input,
  input wire logic [NUM_OUT-1:0] enable_pins,
  input wire logic [NUM_OUT-1:0] out_enable_bits,
  input wire logic ref_enable,
  // reference output drive
  output logic ref_level,
  output logic ref_drive_en,
  // differential output drive
  output logic [NUM_OUT-1:0] diff_run,
  output logic [NUM_OUT-1:0] diff_true_level,
  output logic [NUM_OUT-1:0] diff_comp_level,
  output logic [NUM_OUT-1:0] diff_drive_en,
  // configuration seen by the analog side
  output logic divider_prog_enable,
  output logic [2*NUM_OUT-1:0] output_impedance_field,
  output logic [2*NUM_OUT-1:0] enable_input_termination,
  output logic [1:0] powergood_termination,
  output logic powered_down
);
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_now;
  cgb_pkg::cgb_state_e state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [1:0] wr_phase; // 0 location, 1 count, 2 data
  logic is_read;
  logic [7:0] loc;
  logic [4:0] tx_left;
  logic [6:0] my_addr;
  logic addr_caught;
  logic [4:0] read_length_field;
  logic [7:0] div_retain;
  logic [1:0] disable_state_field;
  logic [7:0] imp_low;
  logic [7:0] imp_high;
  logic [7:0] term_low;
  logic [7:0] term_high;
  logic [1:0] pg_term;
  logic [7:0] enable_input_polarity;
  logic pg_pol;
  logic ack_drive;
  logic [7:0] wr_byte;
  logic wr_strobe;
  logic clear_cfg;

  // edge and start/stop finder
  cgb_line_cond u_line (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .sda_now(sda_now)
  );

  // register read mux
  function automatic logic [7:0] read_loc(input logic [7:0] a, input logic [4:0] rc,
                                         input logic [7:0] dr, input logic [1:0] ds,
                                         input logic [7:0] il, input logic [7:0] ih,
                                         input logic [7:0] tl, input logic [7:0] th,
                                         input logic [1:0] pt, input logic [7:0] ep,
                                         input logic pp);
    case (a)
      cgb_pkg::LOC_REV_VENDOR: read_loc = {REVISION, VENDOR}; // R3
      cgb_pkg::LOC_DEV_TYPE: read_loc = {DEV_TYPE, DEV_IDENT}; // R4
      cgb_pkg::LOC_READ_COUNT: read_loc = {3'h0, rc}; // R5
      cgb_pkg::LOC_DIV_RETAIN: read_loc = {dr[7:6], 6'h00}; // R6 R7
      cgb_pkg::LOC_DIS_STATE: read_loc = {6'h00, ds}; // R2
      cgb_pkg::LOC_IMP_LOW: read_loc = il; // R8
      cgb_pkg::LOC_IMP_HIGH: read_loc = ih; // R8
      cgb_pkg::LOC_TERM_LOW: read_loc = tl; // R9
      cgb_pkg::LOC_TERM_HIGH: read_loc = th; // R10
      cgb_pkg::LOC_PG_TERM: read_loc = {6'h00, pt}; // R11
      cgb_pkg::LOC_EN_POL: read_loc = ep; // R12
      cgb_pkg::LOC_PG_POL: read_loc = {7'h00, pp}; // R13
      default: read_loc = 8'h00; // R14
    endcase
  endfunction

  // address caught after reset release from the select pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      my_addr <= cgb_pkg::ADDR_SEL0;
      addr_caught <= 1'b0;
    end else if (!addr_caught) begin
      my_addr <= bus_address_select_pin ? cgb_pkg::ADDR_SEL1 : cgb_pkg::ADDR_SEL0;
      addr_caught <= 1'b1;
    end
  end

  // protocol engine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cgb_pkg::CGB_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      wr_phase <= 2'h0;
      is_read <= 1'b0;
      loc <= 8'h00;
      tx_left <= 5'h00;
      ack_drive <= 1'b0;
      wr_byte <= 8'h00;
      wr_strobe <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      if (stop_seen) begin
        state <= cgb_pkg::CGB_IDLE;
        ack_drive <= 1'b0;
      end else if (start_seen) begin
        state <= cgb_pkg::CGB_ADDR;
        bit_cnt <= 4'h0;
        ack_drive <= 1'b0;
      end else begin
        case (state)
          cgb_pkg::CGB_ADDR, cgb_pkg::CGB_RX: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_now};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == cgb_pkg::CGB_ADDR) begin
                if (shift[7:1] == my_addr) begin
                  is_read <= shift[0];
                  if (!shift[0]) wr_phase <= 2'h0;
                  ack_drive <= 1'b1;
                  state <= cgb_pkg::CGB_ACK;
                end else begin
                  state <= cgb_pkg::CGB_IDLE;
                end
              end else begin
                ack_drive <= 1'b1; // R15 R18
                state <= cgb_pkg::CGB_ACK;
                case (wr_phase)
                  2'h0: begin
                    loc <= shift;
                    wr_phase <= 2'h1;
                  end
                  2'h1: wr_phase <= 2'h2;
                  default: begin
                    wr_byte <= shift;
                    wr_strobe <= 1'b1; // R15
                  end
                endcase
              end
            end
          end
          cgb_pkg::CGB_ACK: begin
            if (scl_fall) begin
              ack_drive <= 1'b0;
              if (is_read) begin
                tx_left <= read_length_field;
                shift <= {3'h0, read_length_field}; // R16
                state <= cgb_pkg::CGB_TX;
              end else begin
                state <= cgb_pkg::CGB_RX;
              end
            end
          end
          cgb_pkg::CGB_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                bit_cnt <= 4'h0;
                state <= cgb_pkg::CGB_MACK;
              end else begin
                shift <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          // host acknowledge fetches the next byte, not-acknowledge ends the read
          cgb_pkg::CGB_MACK: begin
            if (scl_rise) state <= sda_now ? cgb_pkg::CGB_IDLE : cgb_pkg::CGB_WAIT; // R16
          end
          // exactly read-length data bytes follow the count byte
          cgb_pkg::CGB_WAIT: begin
            if (scl_fall) begin
              if (tx_left != 5'h00) begin
                state <= cgb_pkg::CGB_TX;
                shift <= read_loc(loc, read_length_field, div_retain, disable_state_field,
                                  imp_low, imp_high, term_low, term_high, pg_term,
                                  enable_input_polarity, pg_pol); // R16
                loc <= loc + 8'h01;
                tx_left <= tx_left - 5'h01; // R5
              end else begin
                state <= cgb_pkg::CGB_IDLE; // R16
              end
            end
          end
          default: state <= cgb_pkg::CGB_IDLE;
        endcase
        // stored byte moves the write pointer on
        if (wr_strobe) loc <= loc + 8'h01; // R15
      end
    end
  end

  // open-drain data line: acknowledge or a zero data bit
  always_comb begin
    sda_out = 1'b0;
    sda_oe = ack_drive | (state == cgb_pkg::CGB_TX && !shift[7]);
  end

  // power-down decode and config clear
  assign powered_down = power_good_powerdown_input ~^ pg_pol; // R13
  assign clear_cfg = powered_down & ~div_retain[cgb_pkg::KEEP_CFG_BIT]; // R7

  // writable configuration; read-only and reserved bits stay fixed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_length_field <= cgb_pkg::RST_READ_COUNT;
      div_retain <= cgb_pkg::RST_DIV_RETAIN;
      disable_state_field <= cgb_pkg::RST_DIS_STATE;
      imp_low <= cgb_pkg::RST_IMP;
      imp_high <= cgb_pkg::RST_IMP;
      term_low <= cgb_pkg::RST_TERM;
      term_high <= cgb_pkg::RST_TERM;
      pg_term <= cgb_pkg::RST_PG_TERM;
      enable_input_polarity <= cgb_pkg::RST_EN_POL;
      pg_pol <= cgb_pkg::RST_PG_POL;
    end else if (clear_cfg) begin
      read_length_field <= cgb_pkg::RST_READ_COUNT; // R7
      div_retain <= cgb_pkg::RST_DIV_RETAIN & 8'h80 | (div_retain & 8'h40);
      disable_state_field <= cgb_pkg::RST_DIS_STATE;
      imp_low <= cgb_pkg::RST_IMP;
      imp_high <= cgb_pkg::RST_IMP;
      term_low <= cgb_pkg::RST_TERM;
      term_high <= cgb_pkg::RST_TERM;
      pg_term <= cgb_pkg::RST_PG_TERM;
      enable_input_polarity <= cgb_pkg::RST_EN_POL;
    end else if (wr_strobe) begin
      case (loc)
        cgb_pkg::LOC_READ_COUNT: read_length_field <= wr_byte[4:0]; // R5
        cgb_pkg::LOC_DIV_RETAIN: div_retain <= {wr_byte[7:6], 6'h00}; // R6 R7
        cgb_pkg::LOC_DIS_STATE: disable_state_field <= wr_byte[1:0]; // R2
        cgb_pkg::LOC_IMP_LOW: imp_low <= wr_byte; // R8
        cgb_pkg::LOC_IMP_HIGH: imp_high <= wr_byte; // R8
        cgb_pkg::LOC_TERM_LOW: term_low <= wr_byte; // R9
        cgb_pkg::LOC_TERM_HIGH: term_high <= wr_byte; // R10
        cgb_pkg::LOC_PG_TERM: pg_term <= wr_byte[1:0]; // R11
        cgb_pkg::LOC_EN_POL: enable_input_polarity <= wr_byte; // R12
        cgb_pkg::LOC_PG_POL: pg_pol <= wr_byte[0]; // R13
        default: ; // R18 R14
      endcase
    end
  end

  // configuration outputs
  assign divider_prog_enable = div_retain[cgb_pkg::DIV_PROG_BIT]; // R6
  assign output_impedance_field = {imp_high, imp_low}; // R8
  assign enable_input_termination = {term_high, term_low}; // R9 R10
  assign powergood_termination = pg_term; // R11

  // reference output stop level
  assign ref_level = ref_enable | disable_state_field[0]; // R1
  assign ref_drive_en = ref_enable | (disable_state_field != 2'h1); // R1

  // differential outputs
  cgb_out_ctrl #(
    .NUM_OUT(NUM_OUT)
  ) u_out (
    .out_enable_bits(out_enable_bits),
    .enable_pins(enable_pins),
    .enable_input_polarity(enable_input_polarity),
    .disable_state_field(disable_state_field),
    .powered_down(powered_down),
    .diff_run(diff_run),
    .diff_true_level(diff_true_level),
    .diff_comp_level(diff_comp_level),
    .diff_drive_en(diff_drive_en)
  );
endmodule
`default_nettype wire

// ===== cgb_config_bank_assertions.sv
`default_nettype none
// bus timing and output-state relations of the bank
module cgb_config_bank_assertions #(
  parameter int NUM_OUT = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // inputs
  input wire logic scl_in,
  input wire logic power_good_powerdown_input,
  input wire logic [NUM_OUT-1:0] out_enable_bits,
  input wire logic ref_enable,
  // outputs
  input wire logic sda_oe,
  input wire logic ref_level,
  input wire logic ref_drive_en,
  input wire logic [NUM_OUT-1:0] diff_run,
  input wire logic [NUM_OUT-1:0] diff_true_level,
  input wire logic [NUM_OUT-1:0] diff_comp_level,
  input wire logic [NUM_OUT-1:0] diff_drive_en,
  input wire logic divider_prog_enable,
  input wire logic [2*NUM_OUT-1:0] output_impedance_field,
  input wire logic [2*NUM_OUT-1:0] enable_input_termination,
  input wire logic [1:0] powergood_termination,
  input wire logic powered_down
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // disabled reference follows the field like a stopped output
  a_ref_disable_state: assert property (!ref_enable && !diff_run[0] && !powered_down |->
    ref_drive_en == diff_drive_en[0] && (!ref_drive_en || ref_level == diff_comp_level[0]))
    else $error("reference disable state differs");
  a_stop_not_high: assert property (!diff_run[0] && diff_drive_en[0] |->
    !(diff_true_level[0] && diff_comp_level[0])) else $error("stopped output high/high");
  a_oe_bit_stops: assert property ((diff_run & ~out_enable_bits) == '0)
    else $error("output runs with enable bit cleared");
  a_pd_stops_all: assert property (powered_down |-> diff_run == '0)
    else $error("output runs in power-down");
  a_pd_follows_pin: assert property ($changed(powered_down) |->
    $changed(power_good_powerdown_input) || !scl_in) else $error("power-down moved alone");
  // data line moves only while the serial clock is low
  a_sda_scl_low: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data line moved with clock high");
  // fields change only on a write or a power-down reload
  a_imp_on_write: assert property ($changed(output_impedance_field) |->
    !scl_in || powered_down || $past(powered_down)) else $error("impedance changed");
  a_term_on_write: assert property ($changed(enable_input_termination) |->
    !scl_in || powered_down || $past(powered_down)) else $error("termination changed");
  a_reset_values: assert property ($rose(rst_n) |-> !divider_prog_enable
    && output_impedance_field == '0 && powergood_termination == cgb_pkg::RST_PG_TERM
    && enable_input_termination == {2{cgb_pkg::RST_TERM}}) else $error("bad reset value");
  c_ack: cover property (sda_oe && scl_in);
  c_pd: cover property (powered_down);
  c_stopped: cover property (!diff_run[0] && !diff_drive_en[0]);
endmodule
bind cgb_config_bank cgb_config_bank_assertions #(.NUM_OUT(NUM_OUT)) cgb_config_bank_assertions_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_oe(sda_oe),
  .power_good_powerdown_input(power_good_powerdown_input), .out_enable_bits(out_enable_bits),
  .ref_enable(ref_enable), .ref_level(ref_level), .ref_drive_en(ref_drive_en),
  .diff_run(diff_run), .diff_true_level(diff_true_level), .diff_comp_level(diff_comp_level),
  .diff_drive_en(diff_drive_en), .divider_prog_enable(divider_prog_enable),
  .output_impedance_field(output_impedance_field),
  .enable_input_termination(enable_input_termination),
  .powergood_termination(powergood_termination), .powered_down(powered_down));
`default_nettype wire

// ===== cgb_host_model.sv
`default_nettype none
// bus host: start, stop, byte transfers, block read and write
module cgb_host_model (
  // clock
  input wire logic sys_clk,
  // bus lines
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_low = 1'b0;
  initial scl = 1'b1;
  // pulled-up data line, either party pulls low
  assign sda = !(sda_low || sda_oe);
  // a third of a serial clock period (clock high one, low two), well above four system clocks
  task automatic hp();
    repeat (8) @(posedge sys_clk);
  endtask
  // one bit out, line sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda;
    scl <= 1'b0;
    hp();
  endtask
  // start, also used as repeated start
  task automatic bus_start();
    @(posedge sys_clk);
    sda_low <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b1;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic bus_stop();
    sda_low <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b0;
    hp();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // host acknowledges every byte but the last
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
  // location, count, then bytes for consecutive locations
  task automatic block_write(input logic [6:0] adr, input logic [7:0] loc,
      input logic [7:0] data [16], input int n, output int acks);
    logic a;
    acks = 0;
    bus_start();
    put_byte({adr, 1'b0}, a);
    acks += a;
    put_byte(loc, a);
    acks += a;
    put_byte(8'(n), a);
    acks += a;
    for (int i = 0; i < n; i++) begin
      put_byte(data[i], a);
      acks += a;
    end
    bus_stop();
  endtask
  // location written, repeated start, count byte then data
  task automatic block_read(input logic [7:0] loc, input int n,
      output logic [7:0] cnt, output logic [7:0] data [16]);
    logic a;
    bus_start();
    put_byte({cgb_pkg::ADDR_SEL0, 1'b0}, a);
    put_byte(loc, a);
    bus_start();
    put_byte({cgb_pkg::ADDR_SEL0, 1'b1}, a);
    get_byte(1'b0, cnt);
    for (int i = 0; i < n; i++) get_byte(i == n - 1, data[i]);
    bus_stop();
  endtask
endmodule
`default_nettype wire

// ===== cgb_line_cond.sv
`default_nettype none
// edge and start/stop detection on the serial lines
module cgb_line_cond (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial lines
  input wire logic scl_in,
  input wire logic sda_in,
  // events
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen,
  output logic sda_now
);
  logic scl_q;
  logic sda_q;

  // one stage of history for edge finding
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // events while the clock line is high mark start and stop
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen = scl_in & scl_q & ~sda_q & sda_in;
  assign sda_now = sda_in;
endmodule
`default_nettype wire

// ===== cgb_out_ctrl.sv
`default_nettype none
// per-output disabled-state and enable decoding
module cgb_out_ctrl #(
  parameter int NUM_OUT = 8
) (
  // configuration
  input wire logic [NUM_OUT-1:0] out_enable_bits,
  input wire logic [NUM_OUT-1:0] enable_pins,
  input wire logic [NUM_OUT-1:0] enable_input_polarity,
  input wire logic [1:0] disable_state_field,
  input wire logic powered_down,
  // output drive
  output logic [NUM_OUT-1:0] diff_run,
  output logic [NUM_OUT-1:0] diff_true_level,
  output logic [NUM_OUT-1:0] diff_comp_level,
  output logic [NUM_OUT-1:0] diff_drive_en
);
  // polarity-adjusted pin meets the software enable bit
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    logic pin_on;
    assign pin_on = enable_pins[i] ~^ enable_input_polarity[i];
    assign diff_run[i] = ~powered_down & out_enable_bits[i] & pin_on; // R17
    // stopped level chosen by the field
    assign diff_true_level[i] = (disable_state_field == 2'h2); // R2
    assign diff_comp_level[i] = (disable_state_field == 2'h3); // R2
    assign diff_drive_en[i] = diff_run[i] | (disable_state_field != 2'h1); // R2
  end
endmodule
`default_nettype wire

// ===== cgb_pkg.sv
`default_nettype none
package cgb_pkg;
  // register locations
  localparam logic [7:0] LOC_RSVD_A = 8'h04;
  localparam logic [7:0] LOC_REV_VENDOR = 8'h05;
  localparam logic [7:0] LOC_DEV_TYPE = 8'h06;
  localparam logic [7:0] LOC_READ_COUNT = 8'h07;
  localparam logic [7:0] LOC_RSVD_B = 8'h08;
  localparam logic [7:0] LOC_RSVD_C = 8'h09;
  localparam logic [7:0] LOC_DIV_RETAIN = 8'h0a;
  localparam logic [7:0] LOC_DIS_STATE = 8'h0b;
  localparam logic [7:0] LOC_IMP_LOW = 8'h0c;
  localparam logic [7:0] LOC_IMP_HIGH = 8'h0d;
  localparam logic [7:0] LOC_TERM_LOW = 8'h0e;
  localparam logic [7:0] LOC_TERM_HIGH = 8'h0f;
  localparam logic [7:0] LOC_PG_TERM = 8'h10;
  localparam logic [7:0] LOC_RSVD_D = 8'h11;
  localparam logic [7:0] LOC_EN_POL = 8'h12;
  localparam logic [7:0] LOC_PG_POL = 8'h13;
  // field positions
  localparam int DIV_PROG_BIT = 7;
  localparam int KEEP_CFG_BIT = 6;
  // reset values
  localparam logic [4:0] RST_READ_COUNT = 5'h08;
  localparam logic [7:0] RST_DIV_RETAIN = 8'h40;
  localparam logic [1:0] RST_DIS_STATE = 2'h0;
  localparam logic [7:0] RST_IMP = 8'h00;
  localparam logic [7:0] RST_TERM = 8'h55;
  localparam logic [1:0] RST_PG_TERM = 2'h2;
  localparam logic [7:0] RST_EN_POL = 8'h00;
  localparam logic RST_PG_POL = 1'b0;
  // slave address, sampled from the select pin
  localparam logic [6:0] ADDR_SEL0 = 7'h68;
  localparam logic [6:0] ADDR_SEL1 = 7'h6a;
  // protocol states
  typedef enum logic [2:0] {
    CGB_IDLE = 3'b000,
    CGB_ADDR = 3'b001,
    CGB_ACK = 3'b011,
    CGB_RX = 3'b010,
    CGB_TX = 3'b110,
    CGB_MACK = 3'b111,
    CGB_WAIT = 3'b101
  } cgb_state_e;
endpackage
`default_nettype wire

// ===== tb_cgb_config_bank.sv
`default_nettype none
// self-checking bench for the configuration bank
module tb_cgb_config_bank;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RV = 8'ha6;  // arbitrary revision and vendor
  localparam logic [7:0] TD = 8'h6c;  // arbitrary type and identifier
  localparam logic [7:0] RST_TAB [16] = '{8'h00, RV, TD, 8'h08, 8'h00, 8'h00, 8'h40, 8'h00,
    8'h00, 8'h00, 8'h55, 8'h55, 8'h02, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] ONE_TAB [16] = '{8'h00, RV, TD, 8'h1f, 8'h00, 8'h00, 8'hc0, 8'h03,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h00, 8'hff, 8'h00};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pg_in = 1'b1;
  logic ref_enable = 1'b1;
  logic [7:0] enable_pins = 8'h00;
  logic [7:0] out_enable_bits = 8'hff;
  logic scl, sda, sda_out, sda_oe, ref_level, ref_drive_en, div_en, pd;
  logic [7:0] diff_run, t_lvl, c_lvl, d_en;
  logic [15:0] imp, term;
  logic [1:0] pg_term;
  logic [7:0] ones [16] = '{default: 8'hff};
  int fails = 0;
  int total_checks = 0;
  cgb_config_bank #(.REVISION(RV[7:4]), .VENDOR(RV[3:0]), .DEV_TYPE(TD[7:6]),
    .DEV_IDENT(TD[5:0]), .NUM_OUT(8)) cgb_config_bank_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .bus_address_select_pin(1'b0), .power_good_powerdown_input(pg_in),
    .enable_pins(enable_pins), .out_enable_bits(out_enable_bits), .ref_enable(ref_enable),
    .ref_level(ref_level), .ref_drive_en(ref_drive_en), .diff_run(diff_run),
    .diff_true_level(t_lvl), .diff_comp_level(c_lvl), .diff_drive_en(d_en),
    .divider_prog_enable(div_en), .output_impedance_field(imp),
    .enable_input_termination(term), .powergood_termination(pg_term), .powered_down(pd));
  cgb_host_model cgb_host_model_inst (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // let outputs settle, sample away from the edge
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic wr1(input logic [7:0] loc, input logic [7:0] val);
    logic [7:0] d [16];
    int acks;
    d[0] = val;
    cgb_host_model_inst.block_write(cgb_pkg::ADDR_SEL0, loc, d, 1, acks);
    chk("write acks", 16'h0004, 16'(acks));
  endtask
  // two reads of eight; the first asks a ninth byte, past the count when the count is eight
  task automatic read_all(input logic [7:0] tab [16], input logic [7:0] cnt_exp);
    logic [7:0] cnt;
    logic [7:0] d [16];
    for (int h = 0; h < 2; h++) begin
      cgb_host_model_inst.block_read(8'(4 + 8 * h), 9 - h, cnt, d);
      chk("count byte", 16'(cnt_exp), 16'(cnt));
      for (int i = 0; i < 8; i++)
        chk($sformatf("loc %0d", 8 * h + i + 4), 16'(tab[8 * h + i]), 16'(d[i]));
      if (h == 0) chk("past count", cnt_exp == 8'h08 ? 16'h00ff : 16'(tab[8]), 16'(d[8]));
    end
  endtask
  task automatic t_reset();
    read_all(RST_TAB, 8'h08);
    $display("test reset values done");
  endtask
  task automatic t_foreign();
    int acks;
    cgb_host_model_inst.block_write(cgb_pkg::ADDR_SEL1, 8'h0c, ones, 2, acks);
    chk("foreign acks", 16'h0000, 16'(acks));
    settle();
    chk("impedance kept", 16'h0000, imp);
    chk("sda out", 16'h0000, 16'(sda_out));
    $display("test foreign address done");
  endtask
  task automatic t_write_all();
    int acks;
    // reserved locations 4, 8, 9 and 17 are never written
    cgb_host_model_inst.block_write(cgb_pkg::ADDR_SEL0, 8'h05, ones, 3, acks);
    chk("block acks", 16'h0006, 16'(acks));
    cgb_host_model_inst.block_write(cgb_pkg::ADDR_SEL0, 8'h0a, ones, 7, acks);
    chk("block acks", 16'h000a, 16'(acks));
    cgb_host_model_inst.block_write(cgb_pkg::ADDR_SEL0, 8'h12, ones, 1, acks);
    chk("block acks", 16'h0004, 16'(acks));
    read_all(ONE_TAB, 8'h1f);
    settle();
    chk("impedance", 16'hffff, imp);
    chk("termination", 16'hffff, term);
    chk("pg termination", 16'h0003, 16'(pg_term));
    chk("divider enable", 16'h0001, 16'(div_en));
    $display("test full write done");
  endtask
  task automatic t_disable();
    logic [1:0] c;
    @(posedge sys_clk);
    enable_pins <= 8'hff;
    out_enable_bits <= 8'hfe;
    ref_enable <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr1(cgb_pkg::LOC_DIS_STATE, {6'h00, c});
      settle();
      chk("running", 16'h00fe, 16'(diff_run));
      chk("stopped", 16'({c != 2'h1, c == 2'h2, c == 2'h3}),
        16'({d_en[0], d_en[0] & t_lvl[0], d_en[0] & c_lvl[0]}));
      chk("ref", 16'({c != 2'h1, c == 2'h3}), 16'({ref_drive_en, ref_drive_en & ref_level}));
    end
    $display("test disable states done");
  endtask
  task automatic t_polarity();
    @(posedge sys_clk);
    out_enable_bits <= 8'hff;
    ref_enable <= 1'b1;
    enable_pins <= 8'h0f;
    settle();
    chk("run high pol", 16'h000f, 16'(diff_run));
    wr1(cgb_pkg::LOC_EN_POL, 8'h00);
    settle();
    chk("run low pol", 16'h00f0, 16'(diff_run));
    $display("test polarity done");
  endtask
  task automatic t_powerdown();
    @(posedge sys_clk);
    pg_in <= 1'b0;
    settle();
    chk("pd low", 16'h0001, 16'(pd));
    chk("pd outputs", 16'h0000, 16'(diff_run));
    chk("kept impedance", 16'hffff, imp);
    @(posedge sys_clk);
    pg_in <= 1'b1;
    settle();
    chk("pd off", 16'h0000, 16'(pd));
    wr1(cgb_pkg::LOC_PG_POL, 8'h01);
    settle();
    chk("pd high", 16'h0001, 16'(pd));
    @(posedge sys_clk);
    pg_in <= 1'b0;
    wr1(cgb_pkg::LOC_DIV_RETAIN, 8'h00);
    @(posedge sys_clk);
    pg_in <= 1'b1;
    settle();
    chk("cleared impedance", 16'h0000, imp);
    chk("cleared termination", 16'h5555, term);
    @(posedge sys_clk);
    pg_in <= 1'b0;
    settle();
    chk("pd off high pol", 16'h0000, 16'(pd));
    $display("test power-down done");
  endtask
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_foreign();
    t_write_all();
    t_disable();
    t_polarity();
    t_powerdown();
    results();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    results();
  end
endmodule
`default_nettype wire
